// file: logic/fmd_pkg.sv
// Shared constants and types of the freefall and motion detector.
package fmd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int SAMPLE_W = 14;
    localparam int THS_W = 13;
    localparam int CNT_W = 8;
    localparam int AXES = 3;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [7:0] CFG_ADDR = 8'h15;
    localparam logic [7:0] SRC_ADDR = 8'h16;
    localparam logic [7:0] THS_ADDR = 8'h17;
    localparam logic [7:0] COUNT_ADDR = 8'h18;
    localparam logic [7:0] X_HIGH_ADDR = 8'h73;
    localparam logic [7:0] X_LOW_ADDR = 8'h74;
    localparam logic [7:0] Y_HIGH_ADDR = 8'h75;
    localparam logic [7:0] Y_LOW_ADDR = 8'h76;
    localparam logic [7:0] Z_HIGH_ADDR = 8'h77;
    localparam logic [7:0] Z_LOW_ADDR = 8'h78;

    ////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] SRC_RST = 8'h00;
    localparam logic [7:0] THS_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [6:0] AXIS_HIGH_RST = 7'h00;
    localparam logic [5:0] AXIS_LOW_RST = 6'h00;

    ////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int CFG_LIVE_LSB = 3;
    localparam int THS_MODE_BIT = 7;
    localparam int HIGH_FLAG_BIT = 7;
    localparam int LOW_FIELD_LSB = 2;
    localparam int COMMON_SHIFT = 6;
    localparam int COMMON_MG_PER_LSB = 63;

    ////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic {
        FMD_FREEFALL = 1'b0,
        FMD_MOTION = 1'b1
    } fmd_mode_t;

    typedef struct packed {
        logic latch_en;
        fmd_mode_t mode;
        logic z_en;
        logic y_en;
        logic x_en;
        logic [2:0] rsvd;
    } fmd_cfg_t;

    typedef struct packed {
        logic event_active_flag;
        logic rsvd;
        logic z_evt;
        logic z_neg;
        logic y_evt;
        logic y_neg;
        logic x_evt;
        logic x_neg;
    } fmd_src_t;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] z;
        logic signed [SAMPLE_W-1:0] y;
        logic signed [SAMPLE_W-1:0] x;
    } fmd_accel_t;

endpackage : fmd_pkg

// file: logic/fmd_axis_cmp.sv
// Magnitude and threshold comparison of one acceleration axis.
module fmd_axis_cmp #(
    parameter int SAMPLE_W = 14,
    parameter int THS_W = 13
) (
    // Sample and threshold.
    input wire logic signed [SAMPLE_W-1:0] sample_i,
    input wire logic [THS_W-1:0] thr_i,
    // Results.
    output logic above_o,
    output logic below_o,
    output logic neg_o
);

    logic [SAMPLE_W-1:0] mag;
    logic [SAMPLE_W-1:0] thr_ext;

    if (THS_W >= SAMPLE_W) begin : g_bad_width
        $error("fmd_axis_cmp: threshold must be narrower than sample");
    end

    // The most negative code negates to itself, which read unsigned is
    // exactly its magnitude, so no extra bit is needed.
    assign neg_o = sample_i[SAMPLE_W-1];
    assign mag = neg_o ? SAMPLE_W'(~sample_i + 1'b1) : SAMPLE_W'(sample_i);
    assign thr_ext = SAMPLE_W'(thr_i);
    assign above_o = mag > thr_ext; // RULE17
    assign below_o = mag < thr_ext; // RULE17

endmodule : fmd_axis_cmp

// file: logic/fmd_debounce.sv
// Debounce counter that qualifies the combined detection condition.
module fmd_debounce #(
    parameter int CNT_W = 8
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Control.
    input wire logic step_i,
    input wire logic cond_i,
    input wire logic clear_mode_i,
    input wire logic [CNT_W-1:0] limit_i,
    // Result.
    output logic hit_o,
    output logic [CNT_W-1:0] cnt_o
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    if (CNT_W < 1) begin : g_bad_width
        $error("fmd_debounce: counter width must be at least one");
    end

    always_comb begin
        cnt_d = cnt_q;
        if (cond_i) begin
            if (cnt_q < limit_i) begin
                cnt_d = cnt_q + 1'b1;
            end else begin
                cnt_d = limit_i; // RULE19
            end
        end else if (clear_mode_i) begin
            cnt_d = '0; // RULE13 RULE15
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1; // RULE14 RULE15
        end
    end

    // The event is qualified on the sample that brings the count to the
    // limit, so a limit of zero reports on the first matching sample.
    assign hit_o = cond_i && (cnt_d == limit_i); // RULE19
    assign cnt_o = cnt_q;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= '0;
        end else if (step_i) begin
            cnt_q <= cnt_d; // RULE20
        end
    end

    a_count_clear: assert property ( // RULE13
        @(posedge mclk_i) disable iff (!arst_n_i)
        step_i && !cond_i && clear_mode_i |=> cnt_q == '0)
        else $error("debounce count not cleared on false sample");

    a_count_decr: assert property ( // RULE14
        @(posedge mclk_i) disable iff (!arst_n_i)
        step_i && !cond_i && !clear_mode_i && cnt_q != '0
        |=> cnt_q == $past(cnt_q) - 1'b1)
        else $error("debounce count not decremented by one");

    a_count_bound: assert property ( // RULE19
        @(posedge mclk_i) disable iff (!arst_n_i)
        step_i && cond_i |=> cnt_q <= $past(limit_i))
        else $error("debounce count passed its limit");

endmodule : fmd_debounce

// file: logic/fmd_detector.sv
// Freefall and motion event detector with its register file.
//
// Contract
// RULE1: Latch mode freezes flags; source read clears.
// RULE2: Without latch, source shows live detection.
// RULE3: Mode picks OR of highs or AND of lows.
// RULE4: Per-axis enable bit gates axis detection.
// RULE5: Held latched event blocks new flag updates.
// RULE6: Active flag set when combination is true.
// RULE7: Interrupt from active flag, enabled and routed.
// RULE8: Active flag zero without event, one with.
// RULE9: Axis event flag one when axis detected.
// RULE10: Disabled axis flags always read zero.
// RULE11: Polarity flag zero positive, one negative.
// RULE12: Source register is read-only to software.
// RULE13: Clear mode one zeroes counter on miss.
// RULE14: Clear mode zero decrements counter to zero.
// RULE15: Clear mode same for common or axis thresholds.
// RULE16: Common threshold seven bits, 63 mg, resets zero.
// RULE17: Freefall all below; motion any above threshold.
// RULE18: Axis select ignores common, uses 13-bit thresholds.
// RULE19: Event at debounce count; counter never exceeds it.
// RULE20: Evaluation once per new acceleration sample.
module fmd_detector (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Acceleration samples.
    input wire logic sample_valid_i,
    input wire fmd_pkg::fmd_accel_t accel_i,
    // Register access.
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Interrupt controls from the interrupt enable and route registers.
    input wire logic int_en_i,
    input wire logic int_route_i,
    // Interrupt requests.
    output logic int_line1_o,
    output logic int_line2_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    fmd_pkg::fmd_cfg_t cfg_q;
    logic [7:0] ths_q;
    logic [fmd_pkg::CNT_W-1:0] count_q;
    logic [6:0] high_q [fmd_pkg::AXES];
    logic [5:0] low_q [fmd_pkg::AXES];
    logic axis_thr_sel_q;
    logic trans_thr_sel_q;
    fmd_pkg::fmd_src_t src_q;

    logic src_read;

    assign src_read = reg_rd_i && (reg_addr_i == fmd_pkg::SRC_ADDR);

    // The source register has no write path at all.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_q <= fmd_pkg::fmd_cfg_t'(fmd_pkg::CFG_RST);
            ths_q <= fmd_pkg::THS_RST; // RULE16
            count_q <= fmd_pkg::COUNT_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == fmd_pkg::CFG_ADDR) begin
                cfg_q <= fmd_pkg::fmd_cfg_t'({
                    reg_wdata_i[7:fmd_pkg::CFG_LIVE_LSB],
                    3'h0});
            end else if (reg_addr_i == fmd_pkg::THS_ADDR) begin
                ths_q <= reg_wdata_i; // RULE16
            end else if (reg_addr_i == fmd_pkg::COUNT_ADDR) begin
                count_q <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            axis_thr_sel_q <= 1'b0;
            trans_thr_sel_q <= 1'b0;
            for (int i = 0; i < fmd_pkg::AXES; i++) begin
                high_q[i] <= fmd_pkg::AXIS_HIGH_RST;
                low_q[i] <= fmd_pkg::AXIS_LOW_RST;
            end
        end else if (reg_wr_i) begin
            if (reg_addr_i == fmd_pkg::X_HIGH_ADDR) begin
                axis_thr_sel_q <= reg_wdata_i[fmd_pkg::HIGH_FLAG_BIT];
                high_q[0] <= reg_wdata_i[6:0];
            end else if (reg_addr_i == fmd_pkg::X_LOW_ADDR) begin
                low_q[0] <= reg_wdata_i[7:fmd_pkg::LOW_FIELD_LSB];
            end else if (reg_addr_i == fmd_pkg::Y_HIGH_ADDR) begin
                trans_thr_sel_q <= reg_wdata_i[fmd_pkg::HIGH_FLAG_BIT];
                high_q[1] <= reg_wdata_i[6:0];
            end else if (reg_addr_i == fmd_pkg::Y_LOW_ADDR) begin
                low_q[1] <= reg_wdata_i[7:fmd_pkg::LOW_FIELD_LSB];
            end else if (reg_addr_i == fmd_pkg::Z_HIGH_ADDR) begin
                high_q[2] <= reg_wdata_i[6:0];
            end else if (reg_addr_i == fmd_pkg::Z_LOW_ADDR) begin
                low_q[2] <= reg_wdata_i[7:fmd_pkg::LOW_FIELD_LSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-axis comparison.

    logic [fmd_pkg::AXES-1:0] en;
    logic [fmd_pkg::AXES-1:0] above;
    logic [fmd_pkg::AXES-1:0] below;
    logic [fmd_pkg::AXES-1:0] neg;
    logic [fmd_pkg::AXES-1:0] hit_axis;
    logic signed [fmd_pkg::SAMPLE_W-1:0] smp [fmd_pkg::AXES];
    logic [fmd_pkg::THS_W-1:0] thr [fmd_pkg::AXES];
    logic [fmd_pkg::THS_W-1:0] common_thr;

    assign en = {cfg_q.z_en, cfg_q.y_en, cfg_q.x_en};
    assign smp[0] = accel_i.x;
    assign smp[1] = accel_i.y;
    assign smp[2] = accel_i.z;
    // The common threshold lands on the same bits as the upper field of
    // an axis threshold, so both share one scale.
    assign common_thr = fmd_pkg::THS_W'({ths_q[6:0],
        fmd_pkg::COMMON_SHIFT'(0)}); // RULE16

    for (genvar a = 0; a < fmd_pkg::AXES; a++) begin : g_axis
        assign thr[a] = axis_thr_sel_q ? {high_q[a], low_q[a]}
                                       : common_thr; // RULE18
        fmd_axis_cmp #(
            .SAMPLE_W(fmd_pkg::SAMPLE_W),
            .THS_W(fmd_pkg::THS_W)
        ) u_cmp (
            .sample_i(smp[a]),
            .thr_i(thr[a]),
            .above_o(above[a]),
            .below_o(below[a]),
            .neg_o(neg[a])
        );
        assign hit_axis[a] = en[a] && ((cfg_q.mode == fmd_pkg::FMD_MOTION)
            ? above[a] : below[a]); // RULE4 RULE17
    end

    ////////////////////////////////////////////////////////////////////////
    // Combination and debounce.

    logic cond;
    logic qualified;
    logic [fmd_pkg::CNT_W-1:0] dbc_cnt;

    // With no axis enabled the freefall AND has nothing to agree on, so
    // it is held false rather than firing on every sample.
    always_comb begin
        if (cfg_q.mode == fmd_pkg::FMD_MOTION) begin
            cond = |hit_axis; // RULE3
        end else begin
            cond = (en != '0) && ((hit_axis | ~en) == '1); // RULE3
        end
    end

    fmd_debounce #(
        .CNT_W(fmd_pkg::CNT_W)
    ) u_debounce (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .step_i(sample_valid_i),
        .cond_i(cond),
        .clear_mode_i(ths_q[fmd_pkg::THS_MODE_BIT]),
        .limit_i(count_q),
        .hit_o(qualified),
        .cnt_o(dbc_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Source register.

    fmd_pkg::fmd_src_t src_new;
    logic held;

    always_comb begin
        src_new = fmd_pkg::fmd_src_t'(fmd_pkg::SRC_RST);
        src_new.event_active_flag = qualified; // RULE6 RULE8
        src_new.x_evt = hit_axis[0]; // RULE9
        src_new.y_evt = hit_axis[1]; // RULE9
        src_new.z_evt = hit_axis[2]; // RULE9
        src_new.x_neg = hit_axis[0] && neg[0]; // RULE11
        src_new.y_neg = hit_axis[1] && neg[1]; // RULE11
        src_new.z_neg = hit_axis[2] && neg[2]; // RULE11
    end

    assign held = cfg_q.latch_en && src_q.event_active_flag;

    // A sample arriving with the clearing read wins, so no event is lost.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            src_q <= fmd_pkg::fmd_src_t'(fmd_pkg::SRC_RST);
        end else if (sample_valid_i && (!held || src_read)) begin
            src_q <= src_new; // RULE2 RULE5 RULE20
        end else if (src_read && cfg_q.latch_en) begin
            src_q <= fmd_pkg::fmd_src_t'(fmd_pkg::SRC_RST); // RULE1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port.

    fmd_pkg::fmd_src_t src_view;
    logic [7:0] rd_mux;

    always_comb begin
        src_view = src_q;
        src_view.x_evt = src_q.x_evt && en[0]; // RULE10
        src_view.x_neg = src_q.x_neg && en[0]; // RULE10
        src_view.y_evt = src_q.y_evt && en[1]; // RULE10
        src_view.y_neg = src_q.y_neg && en[1]; // RULE10
        src_view.z_evt = src_q.z_evt && en[2]; // RULE10
        src_view.z_neg = src_q.z_neg && en[2]; // RULE10
    end

    always_comb begin
        if (reg_addr_i == fmd_pkg::CFG_ADDR) begin
            rd_mux = cfg_q;
        end else if (reg_addr_i == fmd_pkg::SRC_ADDR) begin
            rd_mux = src_view; // RULE12
        end else if (reg_addr_i == fmd_pkg::THS_ADDR) begin
            rd_mux = ths_q;
        end else if (reg_addr_i == fmd_pkg::COUNT_ADDR) begin
            rd_mux = count_q;
        end else if (reg_addr_i == fmd_pkg::X_HIGH_ADDR) begin
            rd_mux = {axis_thr_sel_q, high_q[0]};
        end else if (reg_addr_i == fmd_pkg::X_LOW_ADDR) begin
            rd_mux = {low_q[0], 2'h0};
        end else if (reg_addr_i == fmd_pkg::Y_HIGH_ADDR) begin
            rd_mux = {trans_thr_sel_q, high_q[1]};
        end else if (reg_addr_i == fmd_pkg::Y_LOW_ADDR) begin
            rd_mux = {low_q[1], 2'h0};
        end else if (reg_addr_i == fmd_pkg::Z_HIGH_ADDR) begin
            rd_mux = {1'b0, high_q[2]};
        end else if (reg_addr_i == fmd_pkg::Z_LOW_ADDR) begin
            rd_mux = {low_q[2], 2'h0};
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt lines.

    // The request follows the active flag, so it stays up for as long as a
    // latched event is held and drops with the clearing read.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            int_line1_o <= 1'b0;
            int_line2_o <= 1'b0;
        end else begin
            int_line1_o <= src_q.event_active_flag && int_en_i
                && int_route_i; // RULE7
            int_line2_o <= src_q.event_active_flag && int_en_i
                && !int_route_i; // RULE7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_event_latched;
        sample_valid_i && cfg_q.latch_en && qualified;
    endsequence

    sequence s_quiet_no_read;
        !src_read [*2];
    endsequence

    a_latch_freeze: assert property ( // RULE1 RULE5
        s_event_latched ##1 s_quiet_no_read
        |-> cfg_q.latch_en == 1'b0 || $stable(src_q))
        else $error("latched source changed without a read");

    a_read_clears: assert property ( // RULE1
        src_read && cfg_q.latch_en && !sample_valid_i
        |=> src_q == fmd_pkg::fmd_src_t'(fmd_pkg::SRC_RST))
        else $error("source read did not clear latched flags");

    a_live_track: assert property ( // RULE2 RULE6
        sample_valid_i && !cfg_q.latch_en
        |=> src_q.event_active_flag == $past(qualified))
        else $error("live active flag does not follow detection");

    a_motion_or: assert property ( // RULE3
        cfg_q.mode == fmd_pkg::FMD_MOTION |-> cond == |(en & above))
        else $error("motion combination is not an OR");

    a_freefall_and: assert property ( // RULE3 RULE17
        cfg_q.mode == fmd_pkg::FMD_FREEFALL
        |-> cond == ((en != '0) && ((en & below) == en)))
        else $error("freefall combination is not an AND");

    a_disabled_zero: assert property ( // RULE10
        reg_rd_i && reg_addr_i == fmd_pkg::SRC_ADDR && !cfg_q.x_en
        |=> reg_rdata_o[1:0] == 2'b00)
        else $error("disabled axis flags read nonzero");

    a_src_readonly: assert property ( // RULE12
        reg_wr_i && reg_addr_i == fmd_pkg::SRC_ADDR && !sample_valid_i
        && !src_read |=> $stable(src_q))
        else $error("write altered the source register");

    a_irq_route: assert property ( // RULE7
        src_q.event_active_flag && int_en_i
        |=> int_line1_o != int_line2_o)
        else $error("enabled event raised no single interrupt line");

    a_irq_gated: assert property ( // RULE7
        !int_en_i |=> !int_line1_o && !int_line2_o)
        else $error("interrupt raised while disabled");

    a_sample_only: assert property ( // RULE20
        !sample_valid_i && !src_read |=> $stable(src_q))
        else $error("source changed without a sample");

    a_polarity: assert property ( // RULE11
        sample_valid_i && !held && hit_axis[0]
        |=> src_q.x_neg == $past(accel_i.x[fmd_pkg::SAMPLE_W-1]))
        else $error("axis polarity flag wrong");

endmodule : fmd_detector

// file: tb/fmd_sample_model.sv
// Model of the acceleration sample path that feeds the detector.
module fmd_sample_model (
    // Clock.
    input wire logic mclk_i,
    // Sample stream.
    output logic sample_valid_o,
    output fmd_pkg::fmd_accel_t accel_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sample_valid_o = 1'b0;
        accel_o = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One-cycle strobe per sample.
    // The data bus is inverted once the strobe drops, so that nothing
    // downstream can lean on a stale sample.
    task automatic send(input fmd_pkg::fmd_accel_t a);
        @(posedge mclk_i);
        sample_valid_o <= 1'b1;
        accel_o <= a;
        @(posedge mclk_i);
        sample_valid_o <= 1'b0;
        accel_o <= ~a;
    endtask : send

endmodule : fmd_sample_model

// file: tb/fmd_detector_tb.sv
// Self-checking testbench of the freefall and motion detector.
module fmd_detector_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [13:0] P100 = 14'h0064;
    localparam logic [13:0] N100 = 14'h3f9c;
    localparam logic [13:0] P10 = 14'h000a;

    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic sample_valid;
    fmd_pkg::fmd_accel_t accel;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic int_en = 1'b0;
    logic int_route = 1'b0;
    logic int_line1;
    logic int_line2;
    int failures = 0;
    int cmp_count = 0;

    always #20 mclk_i = ~mclk_i;

    fmd_sample_model partner (
        .mclk_i(mclk_i),
        .sample_valid_o(sample_valid),
        .accel_o(accel)
    );

    fmd_detector dut (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .sample_valid_i(sample_valid),
        .accel_i(accel),
        .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr),
        .reg_wdata_i(reg_wdata),
        .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata),
        .reg_rvalid_o(reg_rvalid),
        .int_en_i(int_en),
        .int_route_i(int_route),
        .int_line1_o(int_line1),
        .int_line2_o(int_line2)
    );

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks.
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk_i);
        reg_wr <= 1'b0;
    endtask : wr

    // The read strobe stands for one cycle only, so it is sampled mid-cycle.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk_i);
        reg_rd <= 1'b0;
        @(negedge mclk_i);
        check("read strobe", 8'h01, {7'h00, reg_rvalid});
        check($sformatf("register %h", a), exp, reg_rdata);
    endtask : rd

    task automatic smp(input logic [13:0] x, input logic [13:0] y,
                       input logic [13:0] z);
        partner.send({z, y, x});
    endtask : smp

    task automatic ints(input logic l1, input logic l2);
        check("interrupt lines", {6'h00, l1, l2},
              {6'h00, int_line1, int_line2});
    endtask : ints

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset_and_access();
        logic [7:0] addrs [11];
        addrs = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h73, 8'h74, 8'h75,
                  8'h76, 8'h77, 8'h78, 8'h20};
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        wr(8'h15, 8'hff);
        rd(8'h15, 8'hf8);
        wr(8'h16, 8'hff);
        rd(8'h16, 8'h00);
        wr(8'h74, 8'hff);
        rd(8'h74, 8'hfc);
        wr(8'h77, 8'hff);
        rd(8'h77, 8'h7f);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        wr(8'h15, 8'h00);
        wr(8'h74, 8'h00);
        wr(8'h77, 8'h00);
        $display("test reset and access done");
    endtask : t_reset_and_access

    task automatic t_motion_live();
        int_en <= 1'b1;
        int_route <= 1'b1;
        wr(8'h17, 8'h01);
        wr(8'h15, 8'h48);
        smp(N100, N100, P10);
        rd(8'h16, 8'h83);
        ints(1'b1, 1'b0);
        smp(P10, N100, P10);
        rd(8'h16, 8'h00);
        ints(1'b0, 1'b0);
        $display("test motion live done");
    endtask : t_motion_live

    task automatic t_freefall();
        int_route <= 1'b0;
        wr(8'h17, 8'h02);
        wr(8'h15, 8'h38);
        smp(14'h0010, 14'h3ff0, 14'h0020);
        rd(8'h16, 8'hae);
        ints(1'b0, 1'b1);
        smp(14'h00c8, 14'h3ff0, 14'h0020);
        rd(8'h16, 8'h2c);
        ints(1'b0, 1'b0);
        $display("test freefall done");
    endtask : t_freefall

    task automatic t_latch();
        int_en <= 1'b0;
        wr(8'h17, 8'h01);
        wr(8'h15, 8'hc8);
        smp(P100, P10, P10);
        // The lines follow the active flag one edge after the sample.
        repeat (2) @(negedge mclk_i);
        ints(1'b0, 1'b0);
        smp(P10, P10, P10);
        rd(8'h16, 8'h82);
        rd(8'h16, 8'h00);
        wr(8'h15, 8'h48);
        $display("test latch done");
    endtask : t_latch

    task automatic t_axis_thresholds();
        wr(8'h73, 8'h85);
        smp(14'h00c8, P10, P10);
        rd(8'h16, 8'h00);
        smp(14'h0190, P10, P10);
        rd(8'h16, 8'h82);
        wr(8'h73, 8'h00);
        $display("test axis thresholds done");
    endtask : t_axis_thresholds

    // Hits and expected active flags hold the oldest sample in bit 0, so they read newest sample first.
    task automatic deb(input logic [7:0] ths, input int n,
                       input logic [7:0] hits, input logic [7:0] exp);
        wr(8'h17, ths);
        for (int i = 0; i < n; i++) begin
            smp(hits[i] ? P100 : P10, P10, P10);
            rd(8'h16, {exp[i], 1'b0, 4'h0, hits[i], 1'b0});
        end
    endtask : deb

    task automatic t_debounce();
        wr(8'h18, 8'h03);
        deb(8'h81, 7, 8'b0111_0110, 8'b0100_0000);
        deb(8'h01, 2, 8'b0000_0010, 8'b0000_0010);
        deb(8'h01, 7, 8'b0111_0000, 8'b0100_0000);
        wr(8'h73, 8'h81);
        wr(8'h17, 8'h81);
        // The count still stands at its limit, so the first hit reports.
        deb(8'h81, 4, 8'b0000_1101, 8'b0000_0001);
        wr(8'h73, 8'h00);
        wr(8'h18, 8'h00);
        $display("test debounce done");
    endtask : t_debounce

    ////////////////////////////////////////////////////////////////////////
    // Verdict.
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        $display("wrong value run length expected done seen timeout");
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        t_reset_and_access();
        t_motion_live();
        t_freefall();
        t_latch();
        t_axis_thresholds();
        t_debounce();
        wrap_up();
    end

endmodule : fmd_detector_tb
